// *** hdl/wif_top.sv ***
/*
  watchdog interval select, interrupt enable, sticky interrupt and reset flags,
  with an apb slave holding the control, interrupt status and mask registers.
  assumes pclk is the crystal-derived watchdog clock, that presetn is a
  synchronously released apb reset, and that por_n (power-on only) is not
  asserted by the watchdog reset this block raises.
*/
// Local design decisions: the APB slave port and the address map.
// Behaviour
// - interval timeout sets the interrupt flag
// - interrupt flag reads one, cleared writing one
// - watchdog reset sets a reset flag surviving it
// - reset flag cleared only by writing one or by power-on reset
// - interval select picks two-power interrupt timeout
// - fixed grace count before reset timeout
// - restart bit zeroes counter, self clears
// - reset raised only with reset enable set
// - disable stops and zeroes the counter
// - count clock direct or divided by 256
`include "wif_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module wif_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             wdt_irq,
  output logic             wdt_reset,
  output logic             irq
);

  // last count of the interval for a select code; one bit wider inside so the
  // longest interval does not wrap to zero before the subtraction
  function automatic wif_pkg::wif_count_t interval_last(input logic [1:0] sel);
    logic [20:0] span;  // interval length in ticks
    span          = 21'h000001 << (`WIF_ISEL_BASE + 2 * sel);
    interval_last = wif_pkg::wif_count_t'(span - 21'h000001);
  endfunction

  // control reset word, split per field at reset
  localparam logic [31:0] ctrl_rst_c = `WIF_CTRL_RST;

  // apb handshake and decode
  logic        pready_q;       // access answered this cycle
  logic [31:0] prdata_q;       // read data
  logic        pslverr_q;      // unmapped address
  logic        acc;            // completing access
  logic        wr_ctrl;        // write to control
  logic        wr_istat;       // write to status
  logic        wr_imask;       // write to mask

  // control fields
  logic        en_q;           // watchdog enable
  logic        ie_q;           // interrupt enable
  logic [1:0]  isel_q;         // interval select
  logic        iflag_q;        // sticky interrupt flag
  logic        rflag_q;        // sticky reset flag, power-on reset only
  logic        re_q;           // reset enable
  logic        clkdiv_q;       // divide-by-256 select

  // counting
  logic [7:0]           pre_q;   // prescaler
  logic                 tick;    // one watchdog clock
  wif_pkg::wif_count_t  cnt_q;   // watchdog counter
  wif_pkg::wif_phase_t  phase_q; // timeout phase
  logic                 restart; // restart request
  logic                 to_evt;  // interrupt timeout reached
  logic                 rs_evt;  // reset timeout reached

  // outputs and interrupt registers
  logic       wdt_irq_q;
  logic       wdt_reset_q;
  logic       irq_q;
  logic [1:0] istat_q;
  logic [1:0] imask_q;

  assign acc      = psel & penable & pready_q;
  assign wr_ctrl  = acc & pwrite & (paddr == `WIF_CTRL_OFS);
  assign wr_istat = acc & pwrite & (paddr == `WIF_ISTAT_OFS);
  assign wr_imask = acc & pwrite & (paddr == `WIF_IMASK_OFS);
  assign restart  = wr_ctrl & pwdata[`WIF_RESTART_BIT];

  // answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (psel & penable & ~pready_q) begin
        unique case (paddr)
          `WIF_CTRL_OFS: begin
            prdata_q[`WIF_CLKDIV_BIT]              <= clkdiv_q;
            prdata_q[`WIF_EN_BIT]                  <= en_q;
            prdata_q[`WIF_IE_BIT]                  <= ie_q;
            prdata_q[`WIF_ISEL_HI:`WIF_ISEL_LO]    <= isel_q;
            prdata_q[`WIF_IFLAG_BIT]               <= iflag_q;
            prdata_q[`WIF_RFLAG_BIT]               <= rflag_q;
            prdata_q[`WIF_RST_EN_BIT]              <= re_q;
          end
          `WIF_ISTAT_OFS: prdata_q[1:0] <= istat_q;
          `WIF_IMASK_OFS: prdata_q[1:0] <= imask_q;
          default:        pslverr_q     <= 1'b1;  // unmapped
        endcase
      end
    end
  end

  // writable control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q     <= ctrl_rst_c[`WIF_EN_BIT];
      ie_q     <= ctrl_rst_c[`WIF_IE_BIT];
      isel_q   <= ctrl_rst_c[`WIF_ISEL_HI:`WIF_ISEL_LO];
      re_q     <= ctrl_rst_c[`WIF_RST_EN_BIT];
      clkdiv_q <= ctrl_rst_c[`WIF_CLKDIV_BIT];
    end else if (wr_ctrl) begin
      en_q     <= pwdata[`WIF_EN_BIT];
      ie_q     <= pwdata[`WIF_IE_BIT];
      isel_q   <= pwdata[`WIF_ISEL_HI:`WIF_ISEL_LO];
      re_q     <= pwdata[`WIF_RST_EN_BIT];
      clkdiv_q <= pwdata[`WIF_CLKDIV_BIT];
    end
  end

  // prescaler: tick every clock or every 256th
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 8'h00;
    end else if (!en_q || restart) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end
  assign tick = en_q & (~clkdiv_q | (pre_q == `WIF_PRESCALE_MAX));

  assign to_evt = tick & (phase_q == wif_pkg::wif_counting)
                  & (cnt_q == interval_last(isel_q));
  assign rs_evt = tick & (phase_q == wif_pkg::wif_grace)
                  & (cnt_q == 20'(`WIF_GRACE_CNT - 1));

  // counter and timeout phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 20'h00000;
      phase_q <= wif_pkg::wif_counting;
    end else if (!en_q || restart) begin
      cnt_q   <= 20'h00000;
      phase_q <= wif_pkg::wif_counting;
    end else if (to_evt) begin
      cnt_q   <= 20'h00000;
      phase_q <= wif_pkg::wif_grace;
    end else if (rs_evt) begin
      cnt_q   <= 20'h00000;
      phase_q <= wif_pkg::wif_expired;
    end else if (tick && phase_q != wif_pkg::wif_expired) begin
      cnt_q   <= cnt_q + 20'h00001;
    end
  end

  // interrupt flag: set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iflag_q <= 1'b0;
    end else if (to_evt) begin
      iflag_q <= 1'b1;
    end else if (wr_ctrl && pwdata[`WIF_IFLAG_BIT]) begin
      iflag_q <= 1'b0;
    end
  end

  // reset flag on power-on reset only, so it outlives the watchdog reset
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      rflag_q <= 1'b0;
    end else if (rs_evt && re_q) begin
      rflag_q <= 1'b1;
    end else if (wr_ctrl && pwdata[`WIF_RFLAG_BIT]) begin
      rflag_q <= 1'b0;
    end
  end

  // watchdog interrupt and reset outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_irq_q   <= 1'b0;
      wdt_reset_q <= 1'b0;
    end else begin
      wdt_irq_q   <= iflag_q & ie_q;
      wdt_reset_q <= rs_evt & re_q;
    end
  end

  // interrupt status (w1c, set wins), mask and line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= 2'b00;
      imask_q <= 2'b00;
      irq_q   <= 1'b0;
    end else begin
      istat_q <= (istat_q & ~(wr_istat ? pwdata[1:0] : 2'b00))
                 | {rs_evt & re_q, to_evt};
      if (wr_imask) begin
        imask_q <= pwdata[1:0];
      end
      irq_q   <= |(istat_q & imask_q);
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign wdt_irq   = wdt_irq_q;
  assign wdt_reset = wdt_reset_q;
  assign irq       = irq_q;

  // checks
  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_irq |-> $past(ie_q) && $past(iflag_q)) else $error("irq without enable");
  a_iflag_set: assert property (@(posedge pclk) disable iff (!presetn)
    to_evt |=> iflag_q ##1 (iflag_q || $past(wr_ctrl))) else $error("flag not set");
  a_iflag_hold: assert property (@(posedge pclk) disable iff (!presetn)
    iflag_q && !wr_ctrl |=> iflag_q) else $error("flag lost");
  a_rflag_set: assert property (@(posedge pclk) disable iff (!presetn)
    rs_evt && re_q |=> rflag_q && wdt_reset) else $error("reset flag not set");
  a_rflag_hold: assert property (@(posedge pclk) disable iff (!por_n)
    rflag_q && !(wr_ctrl && pwdata[`WIF_RFLAG_BIT]) |=> rflag_q) else $error("reset flag lost");
  a_itv_len: assert property (@(posedge pclk) disable iff (!presetn)
    to_evt |-> cnt_q == (isel_q == 2'b00 ? 20'h03fff :
                         isel_q == 2'b01 ? 20'h0ffff :
                         isel_q == 2'b10 ? 20'h3ffff : 20'hfffff)) else $error("bad interval");
  a_grace_len: assert property (@(posedge pclk) disable iff (!presetn)
    rs_evt |-> phase_q == wif_pkg::wif_grace && cnt_q == 20'(`WIF_GRACE_CNT - 1))
    else $error("bad grace");
  a_restart_clr: assert property (@(posedge pclk) disable iff (!presetn)
    restart |=> cnt_q == 20'h00000 && phase_q == wif_pkg::wif_counting) else $error("no restart");
  a_reset_gate: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_reset |-> $past(re_q)) else $error("reset while disabled");
  a_disable_clr: assert property (@(posedge pclk) disable iff (!presetn)
    !en_q |=> cnt_q == 20'h00000) else $error("counter kept");
  a_prescale: assert property (@(posedge pclk) disable iff (!presetn)
    tick && clkdiv_q |-> pre_q == 8'hff) else $error("bad prescale");
  c_timeout: cover property (@(posedge pclk) disable iff (!presetn) to_evt);
  c_reset: cover property (@(posedge pclk) disable iff (!presetn) wdt_reset);
  c_clear: cover property (@(posedge pclk) disable iff (!presetn) iflag_q ##1 !iflag_q);

endmodule

`default_nettype wire

// *** inc/wif_cfg.svh ***
/*
  register offsets, field positions, reset values and counts of the watchdog
  interval and flag block. assumes inclusion by bare name from the include path.
*/
`ifndef WIF_CFG_SVH
`define WIF_CFG_SVH

// register byte offsets
`define WIF_CTRL_OFS      12'h000
`define WIF_ISTAT_OFS     12'h004
`define WIF_IMASK_OFS     12'h008

// control field positions
`define WIF_RESTART_BIT   0
`define WIF_RST_EN_BIT    1
`define WIF_RFLAG_BIT     2
`define WIF_IFLAG_BIT     3
`define WIF_ISEL_LO       4
`define WIF_ISEL_HI       5
`define WIF_IE_BIT        6
`define WIF_EN_BIT        7
`define WIF_CLKDIV_BIT    10

// control reset value: divided clock selected
`define WIF_CTRL_RST      32'h0000_0400

// interrupt status bits
`define WIF_EV_TIMEOUT    0
`define WIF_EV_RESET      1

// timing counts in watchdog clocks
`define WIF_ISEL_BASE     14
`define WIF_GRACE_CNT     1024
`define WIF_PRESCALE_MAX  8'hff

`endif

// *** inc/wif_pkg.sv ***
/*
  types of the watchdog interval and flag block.
  assumes nothing of its surroundings.
*/
package wif_pkg;
  // timeout phase of the watchdog counter
  typedef enum logic [1:0] {
    wif_counting = 2'b00,  // running towards the interrupt timeout
    wif_grace    = 2'b01,  // interrupt timeout passed, waiting for reset timeout
    wif_expired  = 2'b10   // reset timeout passed, held until restart or disable
  } wif_phase_t;

  // counter wide enough for the longest interval
  typedef logic [19:0] wif_count_t;
endpackage

// *** testbench/wif_top_test.sv ***
/*
  self-checking bench for the watchdog interval and flag block.
  assumes wif_top as the design, apb master driven here, pclk 125 MHz.
*/
`timescale 1ns/1ps
`default_nettype none
module wif_top_test;
  logic        pclk      = 1'b0;   // apb and count clock
  logic        presetn   = 1'b0;   // bus reset
  logic        por_n     = 1'b0;   // power-on reset
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wdt_irq;
  logic        wdt_reset;
  logic        irq;
  logic [31:0] rd;                 // last read word
  logic        rerr;               // last slave error
  int          error_cnt = 0;
  int          checked   = 0;
  int          rst_seen  = 0;      // reset pulses seen

  // free running clock
  always #4 pclk = ~pclk;

  // count reset pulses
  always @(posedge pclk) begin
    if (wdt_reset === 1'b1) rst_seen <= rst_seen + 1;
  end

  wif_top i_dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_irq(wdt_irq),
    .wdt_reset(wdt_reset), .irq(irq));

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // verdict and end
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      error_cnt++;
      complete_run();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // read control word
  task automatic rdc();
    apb(1'b0, 12'h000, 32'h0);
  endtask

  // reset values, unmapped place
  task automatic t_reset();
    rdc();
    chk("ctrl reset", rd, 32'h400);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", {31'h0, rerr}, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask

  // timeout with interrupt disabled, flag clearing
  task automatic t_noirq();
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h000, 32'h80);
    idle(16384 - 40);
    rdc();
    chk("iflag early", rd & 32'h8, 32'h0);
    idle(60);
    rdc();
    chk("iflag set", rd & 32'h8, 32'h8);
    chk("irq gated", {31'h0, wdt_irq}, 32'h0);
    chk("event irq", {31'h0, irq}, 32'h1);
    idle(1100);
    chk("no reset", rst_seen, 32'h0);
    apb(1'b1, 12'h000, 32'h80);
    rdc();
    chk("iflag w0", rd & 32'h8, 32'h8);
    apb(1'b1, 12'h000, 32'h88);
    rdc();
    chk("iflag w1", rd & 32'h8, 32'h0);
    apb(1'b1, 12'h004, 32'h3);
    idle(2);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask

  // interrupt then reset, flag survives bus reset
  task automatic t_rst_path();
    int n;
    n = 0;
    apb(1'b1, 12'h000, 32'hc3);
    while (wdt_reset !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20000) begin
      error_cnt++;
      complete_run();
    end
    chk("reset time", (n > 17390 && n < 17430), 32'h1);
    chk("irq out", {31'h0, wdt_irq}, 32'h1);
    rdc();
    chk("flags", rd & 32'hc, 32'hc);
    apb(1'b0, 12'h004, 32'h0);
    chk("istat", rd, 32'h3);
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    rdc();
    chk("rflag kept", rd, 32'h404);
    apb(1'b1, 12'h000, 32'h400);
    rdc();
    chk("rflag w0", rd, 32'h404);
    apb(1'b1, 12'h000, 32'h404);
    rdc();
    chk("rflag w1", rd, 32'h400);
  endtask

  // restart and disable zero the count
  task automatic t_restart();
    apb(1'b1, 12'h000, 32'h80);
    idle(10000);
    apb(1'b1, 12'h000, 32'h81);
    rdc();
    chk("restart clears", rd, 32'h80);
    idle(10000);
    rdc();
    chk("restarted", rd & 32'h8, 32'h0);
    idle(6500);
    rdc();
    chk("late flag", rd & 32'h8, 32'h8);
    apb(1'b1, 12'h000, 32'h88);
    idle(1000);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h80);
    idle(10000);
    rdc();
    chk("disable zeroes", rd & 32'h8, 32'h0);
    idle(6500);
    rdc();
    chk("re-enabled count", rd & 32'h8, 32'h8);
  endtask

  // main sequence
  initial begin
    idle(6);
    presetn <= 1'b1;
    por_n <= 1'b1;
    t_reset();
    t_noirq();
    t_rst_path();
    t_restart();
    complete_run();
  end
endmodule
`default_nettype wire
